// ### core/bbfr_defs.svh
`ifndef BBFR_DEFS_SVH
`define BBFR_DEFS_SVH
// What this block does
// - 256-byte user area spans the whole page.
// - Upper half may hold sixteen fault records.
// - Entering a record-write state starts one record.
// - Record holds status as previous state exited.
// - Used-flag reads 1 blank, programmed 0.
// - Record holds previous state and exit cause.
// - Record holds comparator, input, limit status, checksum.
// - Eight bytes, about 250 us each.
// - Finish a record before starting another.
// - Power-on scan finds first slot with flag 1.
// - Slots step eight bytes from region start.
// - Recorder only programs; host erases beforehand.
// - All slots used: write nothing more.
// - After erase, recorder reset repeats the scan.
// - Latched status set feeds the record fields.

// Nonvolatile user area and record region.
`define USER_BASE 16'hf900
`define USER_LAST 16'hf9ff
`define REC_BASE 16'hf980
`define REC_LAST_SLOT 16'hf9f8
`define REC_SLOTS 5'h10
`define REC_BYTES 4'h8
`define REC_BYTE_W 3
`define SLOT_W 4
`define FLAG_BIT 7

// Record byte positions.
`define B_STATE 3'h0
`define B_UV 3'h1
`define B_OV 3'h2
`define B_GPI 3'h3
`define B_LIM 3'h4
`define B_CSUM 3'h7

// Byte program time and the guard that waits for it.
`define CLK_PERIOD_NS 5
`define BYTE_PROG_NS 250000
`define PROG_GUARD_MULT 4
`define PROG_TIMEOUT_CYC (`PROG_GUARD_MULT * `BYTE_PROG_NS / `CLK_PERIOD_NS)

// Register port map.
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_LATCH 4'h8
`define CTRL_RESCAN 0
`define CTRL_ENABLE 1
`define CTRL_RESET 32'h0000_0000
`define ST_DROP 0
`define ST_TMO 1
`define FIFO_DEPTH 4
`endif

// ### core/bbfr_pkg.sv
package bbfr_pkg;
    // Recorder control states, one-hot.
    typedef enum logic [3:0] {
        BBFR_SCAN  = 4'h1,
        BBFR_IDLE  = 4'h2,
        BBFR_WRITE = 4'h4,
        BBFR_FULL  = 4'h8
    } bbfr_state_t;

    // How the previous sequencing state was left.
    typedef enum logic [1:0] {
        BBFR_EXIT_NONE    = 2'h0,
        BBFR_EXIT_SEQ     = 2'h1,
        BBFR_EXIT_TIMEOUT = 2'h2,
        BBFR_EXIT_MONITOR = 2'h3
    } bbfr_exit_t;
endpackage

// ### core/bbfr_recorder.sv
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "bbfr_defs.svh"

module bbfr_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Full and empty come straight from the fill count.
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // Storage is written only on an accepted push.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module bbfr_recorder #(
    parameter int N_SUP = 8,
    parameter int N_GPI = 4,
    parameter int N_LIM = 8,
    parameter int STATE_W = 5,
    parameter int PROG_TIMEOUT_CYC = `PROG_TIMEOUT_CYC
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // Sequencing engine, same clock.
    input wire logic [STATE_W-1:0] sequencing_engine_state,
    input wire logic sequencing_engine_change,
    input wire logic [1:0] sequencing_engine_exit,
    input wire logic sequencing_engine_record_state,
    // Live comparator status, asynchronous.
    input wire logic [N_SUP-1:0] undervoltage_status,
    input wire logic [N_SUP-1:0] overvoltage_status,
    input wire logic [N_GPI-1:0] general_input_status,
    input wire logic [N_LIM-1:0] adc_limit_status,
    // EEPROM array port.
    output logic ee_rd_req,
    output logic ee_wr_req,
    output logic [15:0] ee_addr,
    output logic [7:0] ee_wdata,
    input wire logic ee_done,
    input wire logic [7:0] ee_rdata,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Recorder status.
    output logic rec_busy,
    output logic rec_full
);
    localparam int TW = $clog2(PROG_TIMEOUT_CYC + 1);
    localparam int REC_W = 64 + `SLOT_W;
    localparam int ST_LW = N_SUP * 2 + N_GPI + N_LIM;

    bbfr_pkg::bbfr_state_t state;
    logic [ST_LW-1:0] sync1;
    logic [ST_LW-1:0] sync2;
    logic [ST_LW-1:0] sync3;
    logic [ST_LW-1:0] live;
    logic [ST_LW-1:0] latched;
    logic [STATE_W-1:0] cur_state;
    logic [STATE_W-1:0] prev_state;
    logic [1:0] prev_exit;
    logic cap_pending;
    logic [`SLOT_W:0] alloc;
    logic [`SLOT_W:0] scan_slot;
    logic [`REC_BYTE_W-1:0] byte_idx;
    logic [TW-1:0] timer;
    logic [31:0] ctrl;
    logic drop_flag;
    logic tmo_flag;
    logic rescan_req;
    logic [63:0] next_rec;
    logic [7:0] next_csum;
    logic push;
    logic fifo_ready;
    logic fifo_valid;
    logic fifo_pop;
    logic [REC_W-1:0] head;
    logic byte_last;
    logic timed_out;

    // Three-stage synchroniser; a change counts once stages two and three agree.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            live <= '0;
        end else begin
            sync1 <= {adc_limit_status, general_input_status,
                      overvoltage_status, undervoltage_status};
            sync2 <= sync1;
            sync3 <= sync2;
            live <= (sync2 & sync3) | (live & (sync2 ^ sync3));
        end
    end

    // Latched status and the previous state update on every state change.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            latched <= '0;
            cur_state <= '0;
            prev_state <= '0;
            prev_exit <= bbfr_pkg::BBFR_EXIT_NONE;
        end else if (sequencing_engine_change) begin
            latched <= live;
            cur_state <= sequencing_engine_state;
            prev_state <= cur_state;
            prev_exit <= sequencing_engine_exit;
        end
    end

    // Entering a record-write state asks for a record one cycle later.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cap_pending <= 1'b0;
        end else begin
            cap_pending <= sequencing_engine_change && sequencing_engine_record_state
                           && ctrl[`CTRL_ENABLE] && state != bbfr_pkg::BBFR_SCAN;
        end
    end

    // Record image: flag 0, previous state, cause, status, checksum.
    always_comb begin
        next_rec = '0;
        next_rec[8*`B_STATE +: 8] = {1'b0, prev_exit, 5'(prev_state)};
        next_rec[8*`B_UV +: 8] = 8'(latched[N_SUP-1:0]);
        next_rec[8*`B_OV +: 8] = 8'(latched[2*N_SUP-1:N_SUP]);
        next_rec[8*`B_GPI +: 8] = 8'(latched[2*N_SUP+N_GPI-1:2*N_SUP]);
        next_rec[8*`B_LIM +: 8] = 8'(latched[ST_LW-1:2*N_SUP+N_GPI]);
        next_csum = 8'h00;
        for (int i = 0; i < int'(`B_CSUM); i++) begin
            next_csum = next_csum - next_rec[8*i +: 8];
        end
        next_rec[8*`B_CSUM +: 8] = next_csum;
    end

    // A record is queued only while a free slot remains for it.
    assign push = cap_pending && alloc != `REC_SLOTS;

    bbfr_fifo #(
        .W(REC_W),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data({alloc[`SLOT_W-1:0], next_rec}),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(head)
    );

    assign byte_last = (byte_idx == `REC_BYTE_W'(`REC_BYTES - 4'h1));
    assign timed_out = (timer == TW'(PROG_TIMEOUT_CYC));
    // The head record leaves the queue only after its last byte or a stall.
    assign fifo_pop = state == bbfr_pkg::BBFR_WRITE && ee_wr_req
                      && ((ee_done && byte_last) || timed_out);

    // Slot allocation follows the scan result, kept at the count after a full scan.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            alloc <= `REC_SLOTS;
        end else if (state == bbfr_pkg::BBFR_SCAN || scan_slot == `REC_SLOTS) begin
            alloc <= scan_slot;
        end else if (push && fifo_ready) begin
            alloc <= alloc + 1'b1;
        end
    end

    // Main sequence: scan for the first blank slot, then program records.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= bbfr_pkg::BBFR_SCAN;
            scan_slot <= '0;
            byte_idx <= '0;
            ee_rd_req <= 1'b0;
            ee_wr_req <= 1'b0;
            ee_addr <= `REC_BASE;
            ee_wdata <= 8'hff;
        end else begin
            unique case (state)
                bbfr_pkg::BBFR_SCAN: begin
                    if (ee_rd_req && ee_done) begin
                        ee_rd_req <= 1'b0;
                        if (ee_rdata[`FLAG_BIT]) begin
                            state <= bbfr_pkg::BBFR_IDLE;
                        end else if (scan_slot == `REC_SLOTS - 5'h1) begin
                            scan_slot <= `REC_SLOTS;
                            state <= bbfr_pkg::BBFR_FULL;
                        end else begin
                            scan_slot <= scan_slot + 1'b1;
                        end
                    end else if (!ee_rd_req) begin
                        ee_rd_req <= 1'b1;
                        ee_addr <= `REC_BASE | {9'h0, scan_slot[`SLOT_W-1:0], 3'h0};
                    end
                end
                bbfr_pkg::BBFR_IDLE, bbfr_pkg::BBFR_FULL: begin
                    byte_idx <= '0;
                    if (rescan_req && !fifo_valid) begin
                        scan_slot <= '0;
                        state <= bbfr_pkg::BBFR_SCAN;
                    end else if (fifo_valid) begin
                        state <= bbfr_pkg::BBFR_WRITE;
                    end else if (alloc == `REC_SLOTS) begin
                        state <= bbfr_pkg::BBFR_FULL;
                    end
                end
                bbfr_pkg::BBFR_WRITE: begin
                    if (ee_wr_req && (ee_done || timed_out)) begin
                        ee_wr_req <= 1'b0;
                        byte_idx <= byte_idx + 1'b1;
                        if (byte_last || timed_out) begin
                            byte_idx <= '0;
                            state <= bbfr_pkg::BBFR_IDLE;
                        end
                    end else if (!ee_wr_req) begin
                        // Programming only; no erase is ever issued here.
                        ee_wr_req <= 1'b1;
                        ee_addr <= `REC_BASE
                                   | {9'h0, head[REC_W-1:64], byte_idx};
                        ee_wdata <= head[8*byte_idx +: 8];
                    end
                end
            endcase
        end
    end

    // Guard timer against a byte program that never finishes.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer <= '0;
        end else if (ee_wr_req && !ee_done && !timed_out) begin
            timer <= timer + 1'b1;
        end else begin
            timer <= '0;
        end
    end

    // Control register; rescan stays requested until the scan begins.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= `CTRL_RESET;
            rescan_req <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `REG_CTRL) begin
                ctrl <= reg_wdata;
            end
            if (reg_wr && reg_addr == `REG_CTRL && reg_wdata[`CTRL_RESCAN]) begin
                rescan_req <= 1'b1;
            end else if (state == bbfr_pkg::BBFR_SCAN) begin
                rescan_req <= 1'b0;
            end
        end
    end

    // Sticky errors; a new event wins over a clear in the same cycle.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            drop_flag <= 1'b0;
            tmo_flag <= 1'b0;
        end else begin
            if (cap_pending && !(push && fifo_ready)) begin
                drop_flag <= 1'b1;
            end else if (reg_wr && reg_addr == `REG_STATUS && reg_wdata[`ST_DROP]) begin
                drop_flag <= 1'b0;
            end
            if (timed_out && ee_wr_req) begin
                tmo_flag <= 1'b1;
            end else if (reg_wr && reg_addr == `REG_STATUS && reg_wdata[`ST_TMO]) begin
                tmo_flag <= 1'b0;
            end
        end
    end

    // Read data stand in the cycle after the read strobe only.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `REG_CTRL: reg_rdata <= ctrl;
                `REG_STATUS: reg_rdata <= {16'h0, 3'h0, alloc, state,
                                           2'h0, tmo_flag, drop_flag};
                `REG_LATCH: reg_rdata <= 32'(latched);
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // Status pins for the host to poll or take as an interrupt.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rec_busy <= 1'b1;
            rec_full <= 1'b0;
        end else begin
            rec_busy <= state != bbfr_pkg::BBFR_IDLE && state != bbfr_pkg::BBFR_FULL;
            rec_full <= alloc == `REC_SLOTS && state != bbfr_pkg::BBFR_SCAN;
        end
    end

    // Address of the previous programmed byte, for the order check.
    logic [15:0] last_wr_addr;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            last_wr_addr <= '0;
        end else if (ee_wr_req && ee_done) begin
            last_wr_addr <= ee_addr;
        end
    end

    region_bounds_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (ee_wr_req || ee_rd_req) |-> ee_addr >= `REC_BASE && ee_addr <= `USER_LAST)
        else $error("Recorder access outside the record region.");
    scan_slot_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ee_rd_req |-> ee_addr[2:0] == 3'h0 && state == bbfr_pkg::BBFR_SCAN)
        else $error("Scan read not at a slot flag byte.");
    flag_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (ee_wr_req && ee_addr[2:0] == 3'h0) |-> !ee_wdata[`FLAG_BIT])
        else $error("Used flag not programmed to zero.");
    byte_order_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ($rose(ee_wr_req) && ee_addr[2:0] != 3'h0) |-> ee_addr == last_wr_addr + 16'h1)
        else $error("Record bytes out of ascending order.");
    req_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (ee_wr_req && !ee_done && !timed_out) |=> ee_wr_req && $stable(ee_addr))
        else $error("Program request dropped before completion.");
    one_op_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !(ee_wr_req && ee_rd_req))
        else $error("Read and program requested together.");
    full_stop_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (alloc == `REC_SLOTS && state != bbfr_pkg::BBFR_SCAN) |=> !(push && fifo_ready))
        else $error("Record queued with no free slot.");
    capture_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (sequencing_engine_change && sequencing_engine_record_state
         && ctrl[`CTRL_ENABLE] && state == bbfr_pkg::BBFR_IDLE) |=> cap_pending)
        else $error("Record-write state entry not captured.");
    checksum_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        push |-> next_rec[7:0] + next_rec[15:8] + next_rec[23:16] + next_rec[31:24]
                 + next_rec[39:32] + next_rec[47:40] + next_rec[55:48]
                 + next_rec[63:56] == 8'h00)
        else $error("Record checksum does not sum to zero.");
    latch_src_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sequencing_engine_change |=> latched == $past(live))
        else $error("Latched status not taken at state change.");
endmodule

// ### dv/bbfr_eeprom_model.sv
`timescale 1ns/1ps

module bbfr_eeprom_model (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // Requests from the recorder.
    input wire logic ee_rd_req,
    input wire logic ee_wr_req,
    input wire logic [15:0] ee_addr,
    input wire logic [7:0] ee_wdata,
    // Answers to the recorder.
    output logic ee_done,
    output logic [7:0] ee_rdata
);
    // Array contents, latency set by the bench, and activity logs.
    logic [7:0] mem [0:255];
    logic [15:0] wr_log [0:127];
    logic [15:0] last_rd = 16'h0000;
    logic [15:0] held_addr = 16'h0000;
    int lat = 20;
    int cnt = 0;
    int rd_count = 0;
    int wr_count = 0;
    int bad = 0;

    // The host's erase sets every byte of the page blank again.
    task automatic erase();
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'hff;
        end
    endtask

    // Each request is answered after lat cycles; the read bus toggles when nothing is valid.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ee_done <= 1'b0;
            ee_rdata <= 8'h00;
            cnt <= 0;
        end else if (ee_done || !(ee_rd_req || ee_wr_req)) begin
            ee_done <= 1'b0;
            ee_rdata <= ~ee_rdata;
            cnt <= 0;
        end else begin
            // Overlapping requests, an address off the page or one that moves are faults.
            if ((ee_rd_req && ee_wr_req) || ee_addr[15:8] !== 8'hf9 ||
                (cnt > 0 && ee_addr !== held_addr)) begin
                bad <= bad + 1;
            end
            held_addr <= ee_addr;
            ee_rdata <= ~ee_rdata;
            cnt <= cnt + 1;
            if (cnt + 1 >= lat) begin
                ee_done <= 1'b1;
                if (ee_rd_req) begin
                    ee_rdata <= mem[ee_addr[7:0]];
                    rd_count <= rd_count + 1;
                    last_rd <= ee_addr;
                end else begin
                    // Programming can only clear bits, never set them.
                    mem[ee_addr[7:0]] <= mem[ee_addr[7:0]] & ee_wdata;
                    wr_log[wr_count[6:0]] <= ee_addr;
                    wr_count <= wr_count + 1;
                end
            end
        end
    end
endmodule

// ### dv/bbfr_recorder_test.sv
`timescale 1ns/1ps

module bbfr_recorder_test;
    // Stimulus, observed outputs and bookkeeping.
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] se_state = 5'h00;
    logic se_change = 1'b0;
    logic [1:0] se_exit = 2'h0;
    logic se_rec = 1'b0;
    logic [7:0] uv = 8'h00;
    logic [7:0] ov = 8'h00;
    logic [3:0] gpi = 4'h0;
    logic [7:0] lim = 8'h00;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic ee_rd_req, ee_wr_req, ee_done, rec_busy, rec_full;
    logic [15:0] ee_addr;
    logic [7:0] ee_wdata, ee_rdata;
    logic [31:0] rd;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;

    // The recorder with a short write guard, and the array behind it.
    bbfr_recorder #(.PROG_TIMEOUT_CYC(200)) bbfr_recorder_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .sequencing_engine_state(se_state),
        .sequencing_engine_change(se_change), .sequencing_engine_exit(se_exit),
        .sequencing_engine_record_state(se_rec), .undervoltage_status(uv),
        .overvoltage_status(ov), .general_input_status(gpi), .adc_limit_status(lim),
        .ee_rd_req(ee_rd_req), .ee_wr_req(ee_wr_req), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
        .ee_done(ee_done), .ee_rdata(ee_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rec_busy(rec_busy),
        .rec_full(rec_full));
    bbfr_eeprom_model bbfr_eeprom_model_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .ee_rd_req(ee_rd_req), .ee_wr_req(ee_wr_req),
        .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_done(ee_done), .ee_rdata(ee_rdata));

    // 200 MHz clock and a ceiling on the run length.
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_fail = n_fail + 1;
            complete_run();
        end
    end

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("Checks made: %0d, mismatches: %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Compares one value with its expectation.
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Register port: one-cycle strobes, read data in the cycle after the strobe.
    task automatic reg_write(logic [3:0] a, logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask

    // One sequencing state change pulse.
    task automatic se_step(logic [4:0] s, logic [1:0] x, logic r);
        @(posedge sys_clk);
        se_change <= 1'b1;
        se_state <= s;
        se_exit <= x;
        se_rec <= r;
        @(posedge sys_clk);
        se_change <= 1'b0;
    endtask

    // Bounded waits for the end of a scan and for a count of programmed bytes.
    task automatic wait_busy();
        for (int i = 0; i < 3000 && rec_busy !== 1'b0; i++) @(posedge sys_clk);
        check("rec_busy", rec_busy, 1'b0);
    endtask
    task automatic wait_writes(int target);
        for (int i = 0; i < 6000 && bbfr_eeprom_model_i.wr_count < target; i++) begin
            @(posedge sys_clk);
        end
        check("wr_count", bbfr_eeprom_model_i.wr_count, target);
    endtask

    // Outputs in reset, scan past three used slots, register defaults and a hole.
    task automatic t_reset_scan();
        check("busy_rst", rec_busy, 1'b1);
        check("full_rst", rec_full, 1'b0);
        check("addr_rst", ee_addr, 16'hf980);
        check("wr_rst", ee_wr_req, 1'b0);
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        wait_busy();
        check("scan_reads", bbfr_eeprom_model_i.rd_count, 4);
        check("scan_last", bbfr_eeprom_model_i.last_rd, 16'hf998);
        reg_read(4'h0, rd);
        check("ctrl_rst", rd, 32'h0000_0000);
        reg_read(4'hc, rd);
        check("unmapped", rd, 32'h0000_0000);
        reg_read(4'h4, rd);
        check("status_scan", rd, 32'h0000_0320);
    endtask

    // A record holds the previous state's number, exit cause and status.
    task automatic t_record();
        logic [7:0] exp [0:7];
        logic [7:0] s;
        exp = '{8'h47, 8'h5a, 8'h3c, 8'h0a, 8'hc3, 8'h00, 8'h00, 8'h00};
        s = 8'h00;
        reg_write(4'h0, 32'h0000_0002);
        se_step(5'h07, 2'h1, 1'b0);
        uv <= 8'h5a;
        ov <= 8'h3c;
        gpi <= 4'ha;
        lim <= 8'hc3;
        repeat (8) @(posedge sys_clk);
        se_step(5'h0a, 2'h2, 1'b1);
        uv <= 8'hff;
        lim <= 8'h00;
        wait_writes(8);
        for (int i = 0; i < 7; i++) s = s + exp[i];
        exp[7] = 8'h00 - s;
        for (int i = 0; i < 8; i++) begin
            check("rec_byte", bbfr_eeprom_model_i.mem[8'h98 + i], exp[i]);
            check("rec_addr", bbfr_eeprom_model_i.wr_log[i], 16'hf998 + i);
        end
        reg_read(4'h8, rd);
        check("latched", rd, 32'h0c3a_3c5a);
    endtask

    // Records arriving faster than the array programs fill the queue and drop.
    task automatic t_queue();
        bbfr_eeprom_model_i.lat = 60;
        repeat (7) se_step(5'h03, 2'h3, 1'b1);
        reg_read(4'h4, rd);
        check("dropped", rd[0], 1'b1);
        check("slots", rd[12:8], 5'h08);
        wait_writes(40);
        reg_write(4'h4, 32'h0000_0001);
        reg_read(4'h4, rd);
        check("drop_clr", rd[0], 1'b0);
        bbfr_eeprom_model_i.lat = 20;
    endtask

    // Filling the region: sixteen slots, then nothing more is written.
    task automatic t_full();
        for (int n = 8; n < 16; n++) begin
            se_step(5'h04, 2'h1, 1'b1);
            wait_writes(8 * (n - 2));
        end
        repeat (4) @(posedge sys_clk);
        check("full", rec_full, 1'b1);
        reg_read(4'h4, rd);
        check("status_full", rd[12:4], 9'h108);
        se_step(5'h05, 2'h3, 1'b1);
        repeat (20) @(posedge sys_clk);
        check("no_write", ee_wr_req, 1'b0);
        check("total", bbfr_eeprom_model_i.wr_count, 104);
        for (int i = 0; i < 104; i++) begin
            check("order", bbfr_eeprom_model_i.wr_log[i], 16'hf998 + i);
        end
    endtask

    // A rescan of the used region stays full; after an erase it finds slot zero blank.
    task automatic t_rescan();
        int r0;
        for (int k = 0; k < 2; k++) begin
            r0 = bbfr_eeprom_model_i.rd_count;
            if (k == 1) bbfr_eeprom_model_i.erase();
            reg_write(4'h0, 32'h0000_0003);
            repeat (4) @(posedge sys_clk);
            wait_busy();
            check("rescan_reads", bbfr_eeprom_model_i.rd_count - r0, k ? 1 : 16);
            reg_read(4'h4, rd);
            check("status_rescan", rd[12:4], k ? 9'h002 : 9'h108);
        end
        check("full_clr", rec_full, 1'b0);
    endtask

    // A byte that never finishes ends by the guard and abandons its record.
    task automatic t_timeout();
        int w0;
        w0 = bbfr_eeprom_model_i.wr_count;
        bbfr_eeprom_model_i.lat = 1000;
        se_step(5'h06, 2'h2, 1'b1);
        repeat (300) @(posedge sys_clk);
        check("wr_req_end", ee_wr_req, 1'b0);
        check("no_done", bbfr_eeprom_model_i.wr_count, w0);
        reg_read(4'h4, rd);
        check("timeout", rd[1], 1'b1);
        reg_write(4'h4, 32'h0000_0002);
        reg_read(4'h4, rd);
        check("tmo_clr", rd[1], 1'b0);
        check("slot_used", rd[12:8], 5'h01);
        check("model_faults", bbfr_eeprom_model_i.bad, 0);
    endtask

    // Main sequence: blank array with three used slots, then every scenario.
    initial begin
        bbfr_eeprom_model_i.erase();
        for (int i = 0; i < 3; i++) bbfr_eeprom_model_i.mem[8'h80 + 8 * i] = 8'h41;
        repeat (2) @(posedge sys_clk);
        t_reset_scan();
        t_record();
        t_queue();
        t_full();
        t_rescan();
        t_timeout();
        complete_run();
    end
endmodule
